// *** shared/mpfc_defines.svh ***
// Address map, field layout and timing constants of the pause flow-control block
`ifndef MPFC_DEFINES_SVH
`define MPFC_DEFINES_SVH
// Register byte addresses
`define MPFC_ADR_RX_PAUSE_OPERAND 32'hb00030bc
`define MPFC_ADR_RX_PAUSE_CURRENT_COUNT 32'hb00030c0
`define MPFC_ADR_REMOTE_PAUSE_COUNT 32'hb00030c4
`define MPFC_ADR_RX_FRAME_STATUS 32'hb00030c8
`define MPFC_ADR_MAC_INTERRUPT_ENABLE 32'hb00030e0
`define MPFC_ADR_MAC_INTERRUPT_STATUS 32'hb00030e4
// Reset values
`define MPFC_RST_WORD 16'h0000
`define MPFC_RST_IRQ 3'h0
`define MPFC_RST_RDATA 32'h0000_0000
// Interrupt bit positions (status and mask share the layout)
`define MPFC_IRQ_LEN_TYPE 0
`define MPFC_IRQ_PAUSE_RX 1
`define MPFC_IRQ_REMOTE_DONE 2
`define MPFC_IRQ_W 3
// Timing
`define MPFC_CLK_NS 100
`define MPFC_BIT_NS_10M 100
`define MPFC_BIT_NS_100M 10
`define MPFC_SLOT_BITS 512
`define MPFC_PRE_W 10
`define MPFC_SLOT_CYC(bitNs) ((`MPFC_SLOT_BITS * (bitNs)) / `MPFC_CLK_NS)
`endif

// *** shared/mpfc_pkg.sv ***
// Types shared by the pause flow-control block
`default_nettype none
package mpfc_pkg;
    typedef logic [15:0] mpfc_word_type;
    typedef enum logic [0:0] {
        BUS_IDLE = 1'h0,
        BUS_ACK = 1'h1
    } mpfc_bus_type;
endpackage
`default_nettype wire

// *** hdl/mpfc_top.sv ***
// Pause counters, receive frame status and Wishbone register slave
// Contract
// - Received PAUSE frame operand is stored in the 16-bit operand register.
// - Operand register holds its value while transmission is paused.
// - Operand and both count registers are read only; writes change nothing.
// - Operand counts slot times of 512 bit times each; at 100 Mb/s the code steps every 51 clocks, 510 bit times.
// - Operand loads a down-counter shown live as the current count register.
// - A new PAUSE frame before zero reloads the counter from the new operand.
// - After our own PAUSE frame is sent, a second counter runs from its operand.
// - Every packet's Length/Type field is recorded in the frame status field.
// - Writing one clears a frame status bit; zero leaves it unchanged.
// - With enable set, a received Length/Type sets the flag and raises interrupt.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "mpfc_defines.svh"

// Down-counter stepping once per slot time
module mpfc_slot_down #(
    parameter int CNT_W = 16,
    parameter int PRE_W = `MPFC_PRE_W
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic load,
    input wire logic [CNT_W-1:0] loadVal,
    input wire logic [PRE_W-1:0] slotCyc,
    output logic [CNT_W-1:0] count,
    output logic busy
);
    logic [CNT_W-1:0] count_q, count_d;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic busy_q, busy_d;

    // Reload wins over stepping; prescaler restarts so a full slot follows
    always_comb begin
        count_d = count_q;
        pre_d = pre_q;
        if (load) begin
            count_d = loadVal;
            pre_d = '0;
        end else if (count_q != '0) begin
            if (pre_q == slotCyc - PRE_W'(1)) begin
                pre_d = '0;
                count_d = count_q - CNT_W'(1);
            end else begin
                pre_d = pre_q + PRE_W'(1);
            end
        end
        busy_d = (count_d != '0);
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
            pre_q <= '0;
            busy_q <= 1'h0;
        end else if (clkEn) begin
            count_q <= count_d;
            pre_q <= pre_d;
            busy_q <= busy_d;
        end
    end

    assign count = count_q;
    assign busy = busy_q;
endmodule

module mpfc_top
    import mpfc_pkg::*;
#(
    parameter int ADR_W = 32
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic linkSpeed100,
    input wire logic rxPauseValid,
    input wire logic [15:0] rxPauseOperand,
    input wire logic txPauseDone,
    input wire logic [15:0] txPauseOperand,
    input wire logic rxLenTypeValid,
    input wire logic [15:0] rxLenType,
    output logic txPauseHold,
    output logic irq
);
    localparam int PRE_W = `MPFC_PRE_W;
    localparam logic [PRE_W-1:0] SLOT_10M = PRE_W'(`MPFC_SLOT_CYC(`MPFC_BIT_NS_10M));
    localparam logic [PRE_W-1:0] SLOT_100M = PRE_W'(`MPFC_SLOT_CYC(`MPFC_BIT_NS_100M));

    mpfc_bus_type bus_q, bus_d;
    logic [31:0] rdat_q, rdat_d;
    mpfc_word_type operand_q, operand_d;
    mpfc_word_type frameStatus_q, frameStatus_d;
    logic [`MPFC_IRQ_W-1:0] irqMask_q, irqMask_d, irqStat_q, irqStat_d;
    logic irq_q, irq_d;
    logic [PRE_W-1:0] slotCyc;
    mpfc_word_type rxCount, remoteCount;
    logic rxBusy, remoteBusy, remoteBusyPrev_q;
    logic accept, wrAcc, rdAcc;
    logic [31:0] wmask;

    // Slot length follows the current link speed
    assign slotCyc = linkSpeed100 ? SLOT_100M : SLOT_10M;

    mpfc_slot_down #(.CNT_W(16), .PRE_W(PRE_W)) u_rxPause (
        .sys_clk(sys_clk),
        .reset(reset),
        .clkEn(clkEn),
        .load(rxPauseValid),
        .loadVal(rxPauseOperand),
        .slotCyc(slotCyc),
        .count(rxCount),
        .busy(rxBusy)
    );

    mpfc_slot_down #(.CNT_W(16), .PRE_W(PRE_W)) u_remotePause (
        .sys_clk(sys_clk),
        .reset(reset),
        .clkEn(clkEn),
        .load(txPauseDone),
        .loadVal(txPauseOperand),
        .slotCyc(slotCyc),
        .count(remoteCount),
        .busy(remoteBusy)
    );

    // A request is taken once; ack follows one cycle later
    assign accept = wb_cyc_i && wb_stb_i && (bus_q == BUS_IDLE);
    assign wrAcc = accept && wb_we_i;
    assign rdAcc = accept && !wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Bus state, read data and register updates
    always_comb begin
        bus_d = (accept) ? BUS_ACK : BUS_IDLE;
        rdat_d = rdat_q;
        operand_d = operand_q;
        frameStatus_d = frameStatus_q;
        irqMask_d = irqMask_q;
        irqStat_d = irqStat_q;
        if (rdAcc) begin
            unique case (wb_adr_i)
                `MPFC_ADR_RX_PAUSE_OPERAND: rdat_d = {16'h0000, operand_q};
                `MPFC_ADR_RX_PAUSE_CURRENT_COUNT: rdat_d = {16'h0000, rxCount};
                `MPFC_ADR_REMOTE_PAUSE_COUNT: rdat_d = {16'h0000, remoteCount};
                `MPFC_ADR_RX_FRAME_STATUS: rdat_d = {16'h0000, frameStatus_q};
                `MPFC_ADR_MAC_INTERRUPT_ENABLE: rdat_d = {29'h0, irqMask_q};
                `MPFC_ADR_MAC_INTERRUPT_STATUS: begin
                    rdat_d = {29'h0, irqStat_q};
                    irqStat_d = `MPFC_RST_IRQ; // Read clears
                end
                default: rdat_d = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
        // Only two registers accept writes; the rest ignore them
        if (wrAcc && wb_adr_i == `MPFC_ADR_RX_FRAME_STATUS) begin
            frameStatus_d = frameStatus_q & ~(wb_dat_i[15:0] & wmask[15:0]);
        end
        if (wrAcc && wb_adr_i == `MPFC_ADR_MAC_INTERRUPT_ENABLE) begin
            irqMask_d = (irqMask_q & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);
        end
        // Hardware events come last so a set beats a same-cycle clear
        if (rxPauseValid) begin
            operand_d = rxPauseOperand;
            irqStat_d[`MPFC_IRQ_PAUSE_RX] = 1'h1;
        end
        if (rxLenTypeValid) begin
            frameStatus_d = rxLenType;
            if (irqMask_q[`MPFC_IRQ_LEN_TYPE]) begin
                irqStat_d[`MPFC_IRQ_LEN_TYPE] = 1'h1;
            end
        end
        if (remoteBusyPrev_q && !remoteBusy) begin
            irqStat_d[`MPFC_IRQ_REMOTE_DONE] = 1'h1;
        end
        irq_d = |(irqStat_d & irqMask_d);
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bus_q <= BUS_IDLE;
            rdat_q <= `MPFC_RST_RDATA;
            operand_q <= `MPFC_RST_WORD;
            frameStatus_q <= `MPFC_RST_WORD;
            irqMask_q <= `MPFC_RST_IRQ;
            irqStat_q <= `MPFC_RST_IRQ;
            irq_q <= 1'h0;
            remoteBusyPrev_q <= 1'h0;
        end else if (clkEn) begin
            bus_q <= bus_d;
            rdat_q <= rdat_d;
            operand_q <= operand_d;
            frameStatus_q <= frameStatus_d;
            irqMask_q <= irqMask_d;
            irqStat_q <= irqStat_d;
            irq_q <= irq_d;
            remoteBusyPrev_q <= remoteBusy;
        end
    end

    assign wb_ack_o = (bus_q == BUS_ACK);
    assign wb_dat_o = rdat_q;
    assign txPauseHold = rxBusy;
    assign irq = irq_q;

    // Checks on the block's own outputs and state
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_wr(logic [31:0] a);
        clkEn && wrAcc && wb_adr_i == a;
    endsequence

    property p_operand_capture;
        clkEn && rxPauseValid |=> operand_q == $past(rxPauseOperand);
    endproperty
    a_operand_capture: assert property (p_operand_capture) else $error("operand not captured");

    property p_operand_hold;
        !rxPauseValid |=> $stable(operand_q);
    endproperty
    a_operand_hold: assert property (p_operand_hold) else $error("operand changed without frame");

    property p_ro_write;
        s_wr(`MPFC_ADR_REMOTE_PAUSE_COUNT) ##0 !txPauseDone
            |=> remoteCount == $past(remoteCount) || remoteCount == $past(remoteCount) - 16'h0001;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only register written");

    property p_rx_load;
        clkEn && rxPauseValid |=> rxCount == $past(rxPauseOperand);
    endproperty
    a_rx_load: assert property (p_rx_load) else $error("pause counter not loaded");

    property p_rx_step;
        clkEn && !rxPauseValid && rxCount != 16'h0000
            |=> rxCount == $past(rxCount) || rxCount == $past(rxCount) - 16'h0001;
    endproperty
    a_rx_step: assert property (p_rx_step) else $error("pause counter stepped wrongly");

    property p_hold;
        txPauseHold == (rxCount != 16'h0000);
    endproperty
    a_hold: assert property (p_hold) else $error("hold disagrees with counter");

    property p_remote_load;
        clkEn && txPauseDone |=> remoteCount == $past(txPauseOperand);
    endproperty
    a_remote_load: assert property (p_remote_load) else $error("remote counter not loaded");

    property p_len_type;
        clkEn && rxLenTypeValid |=> frameStatus_q == $past(rxLenType);
    endproperty
    a_len_type: assert property (p_len_type) else $error("length/type not recorded");

    property p_w1c;
        s_wr(`MPFC_ADR_RX_FRAME_STATUS) ##0 (!rxLenTypeValid && wb_sel_i == 4'hf)
            |=> frameStatus_q == ($past(frameStatus_q) & ~$past(wb_dat_i[15:0]));
    endproperty
    a_w1c: assert property (p_w1c) else $error("write-one-clear wrong");

    property p_len_irq;
        clkEn && rxLenTypeValid && irqMask_q[`MPFC_IRQ_LEN_TYPE] |=> irq && irqStat_q[`MPFC_IRQ_LEN_TYPE];
    endproperty
    a_len_irq: assert property (p_len_irq) else $error("length/type interrupt missing");

    property p_reset_zero;
        $fell(reset) |-> operand_q == 16'h0000 && frameStatus_q == 16'h0000 && rxCount == 16'h0000
            && remoteCount == 16'h0000 && !irq;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("state not zero after reset");

    // A frozen enable legally stretches ack, so only a running edge counts
    property p_ack_pulse;
        clkEn && wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

    // A taken request is answered on the very next edge
    sequence s_taken;
        clkEn && accept;
    endsequence

    property p_ack_follow;
        s_taken |=> wb_ack_o;
    endproperty
    a_ack_follow: assert property (p_ack_follow) else $error("request not answered");

    // Reserved upper half never leaks into read data
    property p_upper_zero;
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

    // Remote counter only holds or steps down by one between loads
    property p_remote_step;
        clkEn && !txPauseDone && remoteCount != 16'h0000
            |=> remoteCount == $past(remoteCount) || remoteCount == $past(remoteCount) - 16'h0001;
    endproperty
    a_remote_step: assert property (p_remote_step) else $error("remote counter stepped wrongly");
endmodule
`default_nettype wire

// *** test/mpfc_remote_station.sv ***
// Remote station model: PAUSE frames, own PAUSE completion, packet headers
`timescale 1ns/1ps
`default_nettype none
module mpfc_remote_station
    import mpfc_pkg::*;
(
    input wire logic sys_clk,
    output logic rxPauseValid,
    output mpfc_word_type rxPauseOperand,
    output logic txPauseDone,
    output mpfc_word_type txPauseOperand,
    output logic rxLenTypeValid,
    output mpfc_word_type rxLenType
);
    // Quiet at start; fields hold a pattern nobody should trust
    initial begin
        {rxPauseValid, txPauseDone, rxLenTypeValid} = 3'h0;
        {rxPauseOperand, txPauseOperand, rxLenType} = {3{16'ha5c3}};
    end
    // One-cycle event; fields flip after it so a stale value never looks valid
    task automatic sendEvent(input logic [1:0] kind, input mpfc_word_type v);
        @(posedge sys_clk);
        {rxPauseValid, txPauseDone, rxLenTypeValid} <= {kind == 2'h0, kind == 2'h1, kind == 2'h2};
        {rxPauseOperand, txPauseOperand, rxLenType} <= {3{v}};
        @(posedge sys_clk);
        {rxPauseValid, txPauseDone, rxLenTypeValid} <= 3'h0;
        {rxPauseOperand, txPauseOperand, rxLenType} <= {3{~v}};
    endtask
endmodule
`default_nettype wire

// *** test/tb_mpfc_top.sv ***
// Self-checking bench: pause counters, frame status and interrupt registers
`timescale 1ns/1ps
`default_nettype none
`include "mpfc_defines.svh"
module tb_mpfc_top
    import mpfc_pkg::*;
;
    localparam logic [31:0] aOpr = `MPFC_ADR_RX_PAUSE_OPERAND;
    localparam logic [31:0] aCnt = `MPFC_ADR_RX_PAUSE_CURRENT_COUNT;
    localparam logic [31:0] aRem = `MPFC_ADR_REMOTE_PAUSE_COUNT;
    localparam logic [31:0] aFrm = `MPFC_ADR_RX_FRAME_STATUS;
    localparam logic [31:0] aMsk = `MPFC_ADR_MAC_INTERRUPT_ENABLE;
    localparam logic [31:0] aSts = `MPFC_ADR_MAC_INTERRUPT_STATUS;
    localparam int slotFast = `MPFC_SLOT_CYC(`MPFC_BIT_NS_100M);
    localparam int slotSlow = `MPFC_SLOT_CYC(`MPFC_BIT_NS_10M);
    logic [31:0] regs [7] = '{aOpr, aCnt, aRem, aFrm, aMsk, aSts, 32'hb00030d0};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic clkEn = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic linkSpeed100 = 1'b1;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, rxPauseValid, txPauseDone, rxLenTypeValid, txPauseHold, irq;
    mpfc_word_type rxPauseOperand, txPauseOperand, rxLenType;
    int errCount = 0;
    int checkCount = 0;

    // Free-running system clock
    always #(`MPFC_CLK_NS / 2) sys_clk = ~sys_clk;

    mpfc_top u_dut (.sys_clk, .reset, .clkEn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .linkSpeed100, .rxPauseValid, .rxPauseOperand, .txPauseDone,
        .txPauseOperand, .rxLenTypeValid, .rxLenType, .txPauseHold, .irq);
    mpfc_remote_station u_peer (.sys_clk, .rxPauseValid, .rxPauseOperand, .txPauseDone,
        .txPauseOperand, .rxLenTypeValid, .rxLenType);

    // Verdict and end of run
    task automatic endSim();
        if (errCount == 0 && checkCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle; the answer is awaited, never assumed
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
        if (n >= 20) begin
            errCount++;
            $display("mismatch at %0t: no bus answer", $time);
            endSim();
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask
    // One-slot pause: hold must last one slot at the chosen speed, no more
    task automatic slotRun(input logic s, input int slot);
        int n;
        n = 0;
        @(posedge sys_clk);
        linkSpeed100 <= s;
        u_peer.sendEvent(2'h0, 16'h0001);
        do begin
            @(posedge sys_clk);
            n++;
        end while (txPauseHold === 1'b1 && n < 600);
        chk({31'h0, n >= slot + 1 && n <= slot + 3}, 32'h1);
        // A hold that never ends has already been counted as a mismatch
        if (n >= 600) begin
            endSim();
        end
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'h0;
        // All registers and the hole between frame status and interrupt enable read zero
        foreach (regs[i]) begin
            rd(regs[i], 32'h0);
        end
        chk({31'h0, txPauseHold | irq}, 32'h0);
        // Three-slot pause, with writes aimed at the read-only operand and current count
        u_peer.sendEvent(2'h0, 16'h0003);
        repeat (2) @(negedge sys_clk);
        chk({31'h0, txPauseHold}, 32'h1);
        rd(aOpr, 32'h3);
        rd(aCnt, 32'h3);
        wr(aOpr, 32'hffffffff);
        wr(aCnt, 32'hffffffff);
        repeat (slotFast) @(posedge sys_clk);
        rd(aCnt, 32'h2);
        rd(aOpr, 32'h3);
        // New PAUSE before zero restarts from the new operand
        u_peer.sendEvent(2'h0, 16'h0005);
        rd(aCnt, 32'h5);
        rd(aOpr, 32'h5);
        slotRun(1'h1, slotFast);
        slotRun(1'h0, slotSlow);
        rd(aCnt, 32'h0);
        // Own PAUSE sent: second counter runs and ignores writes
        linkSpeed100 <= 1'h1;
        u_peer.sendEvent(2'h1, 16'h0002);
        wr(aRem, 32'hffffffff);
        rd(aRem, 32'h2);
        repeat (2 * slotFast + 10) @(posedge sys_clk);
        rd(aRem, 32'h0);
        // Masked pause events latch without irq, a read clears them; masked Length/Type never latches
        chk({31'h0, irq}, 32'h0);
        rd(aSts, 32'h6);
        rd(aSts, 32'h0);
        u_peer.sendEvent(2'h2, 16'h0800);
        rd(aFrm, 32'h0800);
        rd(aSts, 32'h0);
        wr(aMsk, 32'h7);
        rd(aMsk, 32'h7);
        u_peer.sendEvent(2'h2, 16'h86dd);
        repeat (2) @(negedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        rd(aFrm, 32'h86dd);
        rd(aSts, 32'h1);
        repeat (2) @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        // Ones clear, zeros keep
        wr(aFrm, 32'hffff00dd);
        rd(aFrm, 32'h8600);
        wr(aFrm, 32'h0);
        rd(aFrm, 32'h8600);
        // Frozen enable must stop the slot prescaler for two whole slots
        u_peer.sendEvent(2'h0, 16'h0002);
        clkEn <= 1'h0;
        repeat (2 * slotFast) @(posedge sys_clk);
        chk({31'h0, txPauseHold}, 32'h1);
        clkEn <= 1'h1;
        rd(aCnt, 32'h2);
        // Reset in mid-pause clears counters, status, mask and the line
        reset <= 1'h1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        chk({31'h0, txPauseHold | irq}, 32'h0);
        rd(aCnt, 32'h0);
        rd(aOpr, 32'h0);
        rd(aFrm, 32'h0);
        rd(aMsk, 32'h0);
        rd(aSts, 32'h0);
        endSim();
    end
endmodule
`default_nettype wire
